// ==== gamma_code_register_bank.sv ====
// Function
// R1: eight channels, each with an 8-bit code register setting its converter.
// R2: converter codes come only from the working registers.
// R3: write-target select is bit 7 of the control register at address 08.
// R4: select 0: channel writes update working register and shadow byte.
// R5: select 1: channel writes update working register only, no programming delay.
// R6: channel reads always return working register contents.
// R7: toggling the select bit leaves all stored codes unchanged.
// R8: at power-up each shadow byte is copied into its working register.
// R9: control register resets to 00h, selecting both copies.
// R10: shadow bytes default to 80h.
// R11: channels 1-4 form the high group, 5-8 the low group.
// R12: code n selects tap n of a 255-step span.
// R13: 7-bit bus address plus read/write bit; one bit follows the select pin.
// R14: select pin low: device answers write address byte E8h.
// R15: shadow programming starts only after the closing stop condition.
// R16: serial interface works up to 400 kHz and at standard-mode timing.
// R17: written channel's converter code changes only at the stop condition.
// R18: address mismatch: ignore the bus until the next start condition.
// R19: master sends the register address as second byte of a write.
// R20: control bits 6 to 0 are reserved, only bit 7 is used.
// R21: addresses 09h upward: writes ignored, reads return a fixed value.
// R22: while programming, show busy and start no further programming.
`timescale 1ns/1ps
module gamma_code_register_bank #(
    parameter int unsigned PROGRAM_CYCLES = gamma_bank_pkg::NV_WRITE_CYCLES
) (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        clk_en,
    input  wire logic        scl,
    input  wire logic        sda_in,
    output logic             sda_out,
    output logic             sda_oe,
    input  wire logic        address_select_pin,
    output logic [3:0][7:0]  high_group_outputs,
    output logic [3:0][7:0]  low_group_outputs,
    output logic             nv_busy
);

    localparam int CH = gamma_bank_pkg::CHANNEL_COUNT;
    localparam int IW = gamma_bank_pkg::INDEX_WIDTH;
    localparam int TW = gamma_bank_pkg::TIMER_WIDTH;

    ////////////////////////////////////////////////////////////////////////////
    // pins in, edge and condition detection
    gamma_bank_pkg::pin_group_type pins_raw;
    gamma_bank_pkg::pin_group_type pins;
    logic                          scl_prev;
    logic                          sda_prev;

    assign pins_raw = '{scl: scl, sda: sda_in, address_select: address_select_pin};

    pin_synchroniser #(
        .WIDTH       ($bits(gamma_bank_pkg::pin_group_type)),
        .RESET_VALUE (gamma_bank_pkg::PIN_IDLE)
    ) u_sync (
        .clk    (clk),
        .rst_n  (rst_n),
        .clk_en (clk_en),
        .d      (pins_raw),
        .q      (pins)
    );

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            scl_prev <= 1'b1;
            sda_prev <= 1'b1;
        end else if (clk_en) begin
            scl_prev <= pins.scl;
            sda_prev <= pins.sda;
        end
    end

    // sampling at 40 MHz leaves ample margin for 400 kHz bit times
    logic scl_rise;
    logic scl_fall;
    logic start_seen;
    logic stop_seen;
    assign scl_rise   = clk_en && pins.scl && !scl_prev; // R16
    assign scl_fall   = clk_en && !pins.scl && scl_prev;
    assign start_seen = clk_en && pins.scl && scl_prev && sda_prev && !pins.sda;
    assign stop_seen  = clk_en && pins.scl && scl_prev && !sda_prev && pins.sda;

    ////////////////////////////////////////////////////////////////////////////
    // storage declarations
    logic [CH-1:0][7:0] working;
    logic [CH-1:0][7:0] staged;
    logic [CH-1:0]      staged_mask;
    logic [7:0]         control;
    logic [CH-1:0]      prog_mask;
    logic [CH-1:0][7:0] prog_data;
    logic [TW-1:0]      prog_timer;
    logic [IW:0]        load_count;
    logic [IW-1:0]      load_prev;
    logic               load_pending;
    logic               loading;
    logic [7:0]         shadow_rd_data;
    assign loading = (load_count != (IW+1)'(CH)) || load_pending;

    ////////////////////////////////////////////////////////////////////////////
    // serial slave
    gamma_bank_pkg::slave_state_type state;
    logic [3:0]  bit_count;
    logic [7:0]  shift;
    logic [7:0]  pointer;
    logic        master_ack;
    logic [6:0]  own_address;
    logic        byte_done;
    logic        write_byte_done;
    logic [7:0]  read_byte;

    always_comb begin
        own_address = gamma_bank_pkg::DEVICE_ADDR_BASE;
        own_address[gamma_bank_pkg::ADDRESS_SELECT_POS] = pins.address_select; // R13 R14
    end
    assign byte_done       = scl_fall && (bit_count == gamma_bank_pkg::BYTE_BITS);
    assign write_byte_done = byte_done && (state == gamma_bank_pkg::SLAVE_WR);

    function automatic logic [7:0] read_value(input logic [7:0] addr,
                                              input logic [CH-1:0][7:0] regs,
                                              input logic [7:0] ctrl);
        if (addr <= gamma_bank_pkg::CHANNEL_LAST_ADDR) begin
            return regs[addr[IW-1:0]]; // R6
        end else if (addr == gamma_bank_pkg::CONTROL_ADDR) begin
            return ctrl;
        end else begin
            return gamma_bank_pkg::RESERVED_READ; // R21
        end
    endfunction

    assign read_byte = read_value(pointer, working, control);
    assign sda_out   = 1'b0;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state      <= gamma_bank_pkg::SLAVE_IDLE;
            bit_count  <= 4'h0;
            shift      <= 8'h00;
            pointer    <= 8'h00;
            master_ack <= 1'b0;
            sda_oe     <= 1'b0;
        end else if (start_seen) begin
            state     <= gamma_bank_pkg::SLAVE_DEV; // R18
            bit_count <= 4'h0;
            sda_oe    <= 1'b0;
        end else if (stop_seen) begin
            state  <= gamma_bank_pkg::SLAVE_IDLE;
            sda_oe <= 1'b0;
        end else begin
            case (state)
                gamma_bank_pkg::SLAVE_DEV, gamma_bank_pkg::SLAVE_REG, gamma_bank_pkg::SLAVE_WR: begin
                    if (scl_rise && bit_count != gamma_bank_pkg::BYTE_BITS) begin
                        shift     <= {shift[6:0], pins.sda};
                        bit_count <= bit_count + 4'h1;
                    end else if (byte_done) begin
                        bit_count <= 4'h0;
                        if (state == gamma_bank_pkg::SLAVE_DEV) begin
                            // busy device declines so no second program can queue
                            if (shift[7:1] == own_address && !nv_busy) begin // R13 R22
                                master_ack <= shift[0];
                                sda_oe     <= 1'b1;
                                state      <= gamma_bank_pkg::SLAVE_DEV_ACK;
                            end else begin
                                state <= gamma_bank_pkg::SLAVE_IGNORE; // R18
                            end
                        end else if (state == gamma_bank_pkg::SLAVE_REG) begin
                            pointer <= shift; // R19
                            sda_oe  <= 1'b1;
                            state   <= gamma_bank_pkg::SLAVE_REG_ACK;
                        end else begin
                            pointer <= pointer + 8'h01;
                            sda_oe  <= 1'b1;
                            state   <= gamma_bank_pkg::SLAVE_WR_ACK;
                        end
                    end
                end
                gamma_bank_pkg::SLAVE_DEV_ACK: begin
                    if (scl_fall) begin
                        if (master_ack) begin
                            shift     <= {read_byte[6:0], 1'b0};
                            sda_oe    <= !read_byte[7];
                            bit_count <= 4'h1;
                            state     <= gamma_bank_pkg::SLAVE_RD;
                        end else begin
                            sda_oe <= 1'b0;
                            state  <= gamma_bank_pkg::SLAVE_REG;
                        end
                    end
                end
                gamma_bank_pkg::SLAVE_REG_ACK, gamma_bank_pkg::SLAVE_WR_ACK: begin
                    if (scl_fall) begin
                        sda_oe <= 1'b0;
                        state  <= gamma_bank_pkg::SLAVE_WR;
                    end
                end
                gamma_bank_pkg::SLAVE_RD: begin
                    if (byte_done) begin
                        sda_oe  <= 1'b0;
                        pointer <= pointer + 8'h01;
                        state   <= gamma_bank_pkg::SLAVE_RD_ACK;
                    end else if (scl_fall) begin
                        sda_oe    <= !shift[7];
                        shift     <= shift << 1;
                        bit_count <= bit_count + 4'h1;
                    end
                end
                gamma_bank_pkg::SLAVE_RD_ACK: begin
                    if (scl_rise) begin
                        master_ack <= !pins.sda;
                    end else if (scl_fall) begin
                        if (master_ack) begin
                            shift     <= {read_byte[6:0], 1'b0};
                            sda_oe    <= !read_byte[7];
                            bit_count <= 4'h1;
                            state     <= gamma_bank_pkg::SLAVE_RD;
                        end else begin
                            state <= gamma_bank_pkg::SLAVE_IGNORE;
                        end
                    end
                end
                default: begin
                    sda_oe <= 1'b0;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // staging: written codes wait here for the stop condition
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            staged      <= '0;
            staged_mask <= '0;
        end else if (stop_seen) begin
            staged_mask <= '0;
        end else if (write_byte_done && pointer <= gamma_bank_pkg::CHANNEL_LAST_ADDR) begin // R21
            staged[pointer[IW-1:0]]      <= shift;
            staged_mask[pointer[IW-1:0]] <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // control register
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            control <= gamma_bank_pkg::CONTROL_RESET; // R9
        end else if (write_byte_done && pointer == gamma_bank_pkg::CONTROL_ADDR) begin // R3
            // only the mode bit is stored; codes are untouched
            control <= gamma_bank_pkg::CONTROL_RESET;
            control[gamma_bank_pkg::MODE_BIT] <= shift[gamma_bank_pkg::MODE_BIT]; // R20 R7
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // power-up load and working registers
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            load_count   <= '0;
            load_prev    <= '0;
            load_pending <= 1'b0;
        end else if (clk_en) begin
            load_prev    <= load_count[IW-1:0];
            load_pending <= (load_count != (IW+1)'(CH));
            if (load_count != (IW+1)'(CH)) begin
                load_count <= load_count + 1'b1;
            end
        end
    end

    genvar ch;
    for (ch = 0; ch < CH; ch++) begin : g_working
        always_ff @(posedge clk) begin
            if (!rst_n) begin
                working[ch] <= gamma_bank_pkg::SHADOW_DEFAULT;
            end else if (clk_en && load_pending && load_prev == IW'(ch)) begin
                working[ch] <= shadow_rd_data; // R8
            end else if (stop_seen && staged_mask[ch]) begin
                working[ch] <= staged[ch]; // R17 R4 R5
            end
        end
    end

    // converters are fed from the working copies only
    assign high_group_outputs = working[gamma_bank_pkg::GROUP_SIZE-1:0]; // R1 R2 R11 R12
    assign low_group_outputs  = working[CH-1:gamma_bank_pkg::GROUP_SIZE]; // R11

    ////////////////////////////////////////////////////////////////////////////
    // shadow programming, one byte per write time
    logic          mem_wr_en;
    logic [IW-1:0] mem_wr_index;
    always_comb begin
        mem_wr_index = '0;
        for (int i = CH - 1; i >= 0; i--) begin
            if (prog_mask[i]) begin
                mem_wr_index = IW'(i);
            end
        end
    end
    assign mem_wr_en = clk_en && !loading && (prog_mask != '0) && (prog_timer == '0);

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            prog_mask  <= '0;
            prog_data  <= '0;
            prog_timer <= '0;
        end else if (stop_seen && !control[gamma_bank_pkg::MODE_BIT] && staged_mask != '0) begin // R15 R4 R5
            prog_mask <= staged_mask;
            prog_data <= staged;
        end else if (mem_wr_en) begin
            prog_mask[mem_wr_index] <= 1'b0;
            prog_timer              <= TW'(PROGRAM_CYCLES - 1);
        end else if (clk_en && prog_timer != '0) begin
            prog_timer <= prog_timer - 1'b1; // R22
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            nv_busy <= 1'b1;
        end else if (clk_en) begin
            nv_busy <= loading || (prog_mask != '0) || (prog_timer != '0) || stop_seen; // R22
        end
    end

    nv_shadow_memory #(
        .DEPTH       (CH),
        .WIDTH       (gamma_bank_pkg::CODE_WIDTH),
        .INDEX_WIDTH (IW),
        .FILL        (gamma_bank_pkg::SHADOW_DEFAULT)
    ) u_shadow (
        .clk      (clk),
        .clk_en   (clk_en),
        .wr_en    (mem_wr_en),
        .wr_index (mem_wr_index),
        .wr_data  (prog_data[mem_wr_index]),
        .rd_index (load_count[IW-1:0]),
        .rd_data  (shadow_rd_data)
    );

endmodule

// ==== gamma_bank_pkg.sv ====
package gamma_bank_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // geometry
    localparam int CHANNEL_COUNT    = 8;
    localparam int CODE_WIDTH       = 8;
    localparam int GROUP_SIZE       = 4;
    localparam int INDEX_WIDTH      = 3;
    localparam int BIT_COUNT_WIDTH  = 4;
    localparam logic [3:0] BYTE_BITS = 4'h8;

    ////////////////////////////////////////////////////////////////////////////
    // register map and values
    localparam logic [7:0] CHANNEL_LAST_ADDR = 8'h07;
    localparam logic [7:0] CONTROL_ADDR      = 8'h08;
    localparam int         MODE_BIT          = 7;
    localparam logic [7:0] CONTROL_RESET     = 8'h00;
    localparam logic [7:0] SHADOW_DEFAULT    = 8'h80;
    localparam logic [7:0] RESERVED_READ     = 8'hff;

    ////////////////////////////////////////////////////////////////////////////
    // bus address: base with the select bit at zero
    localparam logic [6:0] DEVICE_ADDR_BASE   = 7'h74;
    localparam int         ADDRESS_SELECT_POS = 0;

    ////////////////////////////////////////////////////////////////////////////
    // timing
    localparam int CLOCK_MHZ        = 40;
    localparam int NV_WRITE_TIME_US = 20000;
    localparam int NV_WRITE_CYCLES  = NV_WRITE_TIME_US * CLOCK_MHZ;
    localparam int TIMER_WIDTH      = 20;

    ////////////////////////////////////////////////////////////////////////////
    // types
    typedef enum logic [3:0] {
        SLAVE_IDLE    = 4'h0,
        SLAVE_DEV     = 4'h1,
        SLAVE_DEV_ACK = 4'h2,
        SLAVE_REG     = 4'h3,
        SLAVE_REG_ACK = 4'h4,
        SLAVE_WR      = 4'h5,
        SLAVE_WR_ACK  = 4'h6,
        SLAVE_RD      = 4'h7,
        SLAVE_RD_ACK  = 4'h8,
        SLAVE_IGNORE  = 4'h9
    } slave_state_type;

    typedef struct packed {
        logic scl;
        logic sda;
        logic address_select;
    } pin_group_type;

    localparam pin_group_type PIN_IDLE = '{scl: 1'b1, sda: 1'b1, address_select: 1'b0};

endpackage

// ==== pin_synchroniser.sv ====
`timescale 1ns/1ps
module pin_synchroniser #(
    parameter int         WIDTH      = 1,
    parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic             clk_en,
    input  wire logic [WIDTH-1:0] d,
    output logic      [WIDTH-1:0] q
);

    logic [WIDTH-1:0] first;

    // first stage is read only by the second
    genvar i;
    for (i = 0; i < WIDTH; i++) begin : g_bit
        always_ff @(posedge clk) begin
            if (!rst_n) begin
                first[i] <= RESET_VALUE[i];
                q[i]     <= RESET_VALUE[i];
            end else if (clk_en) begin
                first[i] <= d[i];
                q[i]     <= first[i];
            end
        end
    end

endmodule

// ==== nv_shadow_memory.sv ====
`timescale 1ns/1ps
module nv_shadow_memory #(
    parameter int         DEPTH       = gamma_bank_pkg::CHANNEL_COUNT,
    parameter int         WIDTH       = gamma_bank_pkg::CODE_WIDTH,
    parameter int         INDEX_WIDTH = gamma_bank_pkg::INDEX_WIDTH,
    parameter logic [WIDTH-1:0] FILL  = gamma_bank_pkg::SHADOW_DEFAULT
) (
    input  wire logic                   clk,
    input  wire logic                   clk_en,
    input  wire logic                   wr_en,
    input  wire logic [INDEX_WIDTH-1:0] wr_index,
    input  wire logic [WIDTH-1:0]       wr_data,
    input  wire logic [INDEX_WIDTH-1:0] rd_index,
    output logic      [WIDTH-1:0]       rd_data
);

    logic [WIDTH-1:0] cells [0:DEPTH-1];

    // contents survive rst_n: only the factory fill and programming writes set them
    initial begin
        for (int i = 0; i < DEPTH; i++) begin
            cells[i] = FILL; // R10
        end
    end

    always_ff @(posedge clk) begin
        if (clk_en && wr_en) begin
            cells[wr_index] <= wr_data;
        end
    end

    always_ff @(posedge clk) begin
        if (clk_en) begin
            rd_data <= cells[rd_index];
        end
    end

endmodule

// ==== gamma_bank_checker.sv ====
`timescale 1ns/1ps
module gamma_bank_checker #(
    parameter int unsigned PROGRAM_CYCLES = gamma_bank_pkg::NV_WRITE_CYCLES
) (
    input wire logic            clk,
    input wire logic            rst_n,
    input wire logic            clk_en,
    input wire logic            scl,
    input wire logic            sda_in,
    input wire logic            sda_out,
    input wire logic            sda_oe,
    input wire logic            address_select_pin,
    input wire logic [3:0][7:0] high_group_outputs,
    input wire logic [3:0][7:0] low_group_outputs,
    input wire logic            nv_busy
);
    ////////////////////////////////////////////////////////////////////////////
    // length of the current busy run; eight queued bytes is the worst case
    logic [31:0] busy_run;

    always_ff @(posedge clk) begin
        if (!rst_n || !nv_busy) begin
            busy_run <= 32'h0000_0000;
        end else begin
            busy_run <= busy_run + 32'h0000_0001;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_reset_view: assert property ($rose(rst_n) |-> nv_busy && !sda_oe
        && high_group_outputs == {4{8'h80}} && low_group_outputs == {4{8'h80}})
        else $error("outputs not at reset values on release");
    a_load_bound: assert property ($rose(rst_n) |-> ##[1:24] !nv_busy)
        else $error("power-up load too long");
    a_codes_at_stop: assert property (($changed(high_group_outputs) || $changed(low_group_outputs))
        |-> scl && sda_in) else $error("code changed outside a stop");
    a_busy_quiet: assert property (nv_busy && $past(nv_busy) |-> !sda_oe)
        else $error("device drove the bus while busy");
    a_oe_scl_low: assert property ($changed(sda_oe) |-> !$past(scl, 2))
        else $error("data line moved while clock high");
    a_ack_holds: assert property ($rose(sda_oe) |=> sda_oe [*4])
        else $error("driven bit shorter than a bit time");
    a_drain_open: assert property (sda_oe |-> sda_out == 1'b0)
        else $error("data line driven high");
    a_busy_bound: assert property (busy_run <= 32'(8 * PROGRAM_CYCLES + 32))
        else $error("busy run too long");
endmodule

bind gamma_code_register_bank gamma_bank_checker #(.PROGRAM_CYCLES(PROGRAM_CYCLES)) i_gamma_bank_checker (
    .clk(clk), .rst_n(rst_n), .clk_en(clk_en), .scl(scl), .sda_in(sda_in), .sda_out(sda_out),
    .sda_oe(sda_oe), .address_select_pin(address_select_pin), .high_group_outputs(high_group_outputs),
    .low_group_outputs(low_group_outputs), .nv_busy(nv_busy));

// ==== gamma_bus_master.sv ====
`timescale 1ns/1ps
module gamma_bus_master (
    output logic     scl,
    output logic     sda_low,
    input wire logic sda
);
    // bit time 200 ns; clock idles high between frames
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic start;
        #25 sda_low = 1'b0;
        #75 scl = 1'b1;
        #100 sda_low = 1'b1;
        #100 scl = 1'b0;
    endtask

    task automatic stop;
        #25 sda_low = 1'b1;
        #75 scl = 1'b1;
        #100 sda_low = 1'b0;
        #200;
    endtask

    // sample mid-high: the device answers a few system clocks after the fall
    task automatic clock_bit(input logic b, output logic s);
        #25 sda_low = ~b;
        #75 scl = 1'b1;
        #50 s = sda;
        #50 scl = 1'b0;
    endtask

    task automatic send(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            clock_bit(d[i], s);
        end
        clock_bit(1'b1, s);
        ack = ~s;
    endtask

    task automatic recv(input logic ack, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            clock_bit(1'b1, d[i]);
        end
        clock_bit(~ack, s);
    endtask
endmodule

// ==== tb_gamma_code_register_bank.sv ====
`timescale 1ns/1ps
module tb_gamma_code_register_bank;
    localparam int PROG = 200;
    localparam logic [7:0] CODES [8] = '{8'h00, 8'hff, 8'h01, 8'hfe, 8'h7f, 8'h80, 8'haa, 8'h55};

    logic            clk = 1'b0;
    logic            rst_n = 1'b0;
    logic            address_select_pin = 1'b0;
    logic            scl;
    logic            sda_low;
    logic            sda_in;
    logic            sda_out;
    logic            sda_oe;
    logic [3:0][7:0] high_group_outputs;
    logic [3:0][7:0] low_group_outputs;
    logic            nv_busy;
    logic            ack;
    logic [7:0]      v;
    int              mismatches = 0;
    int              n_compared = 0;
    int              cyc = 0;

    // pull-up on the shared data line
    assign sda_in = !(sda_oe || sda_low);

    initial begin
        forever #12.5 clk = ~clk;
    end

    always @(posedge clk) cyc <= cyc + 1;

    gamma_code_register_bank #(.PROGRAM_CYCLES(PROG)) i_gamma_code_register_bank (
        .clk(clk), .rst_n(rst_n), .clk_en(1'b1), .scl(scl), .sda_in(sda_in), .sda_out(sda_out),
        .sda_oe(sda_oe), .address_select_pin(address_select_pin), .high_group_outputs(high_group_outputs),
        .low_group_outputs(low_group_outputs), .nv_busy(nv_busy));

    gamma_bus_master i_gamma_bus_master (.scl(scl), .sda_low(sda_low), .sda(sda_in));

    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic put(input logic [7:0] b, input logic want);
        i_gamma_bus_master.send(b, ack);
        chk("ack", {7'h00, ack}, {7'h00, want});
    endtask

    task automatic idle;
        repeat (4) @(posedge clk);
        for (int i = 0; i < 4000 && nv_busy !== 1'b0; i++) @(posedge clk);
        #2;
        chk("idle", {7'h00, nv_busy}, 8'h00);
    endtask

    task automatic wr(input logic [7:0] ra, input logic [7:0] d);
        i_gamma_bus_master.start();
        put(8'he8, 1'b1);
        put(ra, 1'b1);
        put(d, 1'b1);
        i_gamma_bus_master.stop();
        idle();
    endtask

    task automatic see(input logic [7:0] ra, input logic [7:0] exp);
        i_gamma_bus_master.start();
        put(8'he8, 1'b1);
        put(ra, 1'b1);
        i_gamma_bus_master.start();
        put(8'he9, 1'b1);
        i_gamma_bus_master.recv(1'b0, v);
        i_gamma_bus_master.stop();
        chk("read", v, exp);
    endtask

    task automatic do_reset;
        @(posedge clk);
        #2 rst_n = 1'b0;
        repeat (6) @(posedge clk);
        #2 rst_n = 1'b1;
        idle();
    endtask

    ////////////////////////////////////////////////////////////////////////////
    task automatic t_power;
        for (int i = 0; i < 4; i++) begin
            chk("high code", high_group_outputs[i], 8'h80);
            chk("low code", low_group_outputs[i], 8'h80);
        end
        see(8'h08, 8'h00);
        see(8'h03, 8'h80);
        $display("test power done");
    endtask

    task automatic t_mode0;
        int t0;
        i_gamma_bus_master.start();
        put(8'he8, 1'b1);
        put(8'h02, 1'b1);
        put(8'h55, 1'b1);
        put(8'h66, 1'b1);
        repeat (8) @(posedge clk);
        #2;
        chk("before stop", high_group_outputs[2], 8'h80);
        chk("no early program", {7'h00, nv_busy}, 8'h00);
        i_gamma_bus_master.stop();
        t0 = cyc;
        chk("ch3 at stop", high_group_outputs[2], 8'h55);
        chk("ch4 at stop", high_group_outputs[3], 8'h66);
        i_gamma_bus_master.start();
        put(8'he8, 1'b0);
        i_gamma_bus_master.stop();
        idle();
        chk("program time", {7'h00, (cyc - t0 >= 2 * PROG - 4)}, 8'h01);
        do_reset();
        chk("ch3 reload", high_group_outputs[2], 8'h55);
        chk("ch4 reload", high_group_outputs[3], 8'h66);
        $display("test mode0 done");
    endtask

    task automatic t_mode1;
        wr(8'h08, 8'h80);
        see(8'h08, 8'h80);
        i_gamma_bus_master.start();
        put(8'he8, 1'b1);
        put(8'h00, 1'b1);
        for (int i = 0; i < 8; i++) put(CODES[i], 1'b1);
        i_gamma_bus_master.stop();
        chk("no programming", {7'h00, nv_busy}, 8'h00);
        for (int i = 0; i < 4; i++) begin
            chk("high map", high_group_outputs[i], CODES[i]);
            chk("low map", low_group_outputs[i], CODES[i + 4]);
        end
        see(8'h05, CODES[5]);
        wr(8'h08, 8'h00);
        for (int i = 0; i < 4; i++) chk("kept", high_group_outputs[i], CODES[i]);
        do_reset();
        chk("shadow untouched", high_group_outputs[2], 8'h55);
        chk("default kept", high_group_outputs[0], 8'h80);
        $display("test mode1 done");
    endtask

    task automatic t_reserved;
        wr(8'h09, 8'h33);
        see(8'h09, gamma_bank_pkg::RESERVED_READ);
        wr(8'h08, 8'h7f);
        see(8'h08, 8'h00);
        chk("no side effect", high_group_outputs[2], 8'h55);
        $display("test reserved done");
    endtask

    task automatic t_address;
        @(posedge clk);
        #2 address_select_pin = 1'b1;
        i_gamma_bus_master.start();
        put(8'he8, 1'b0);
        put(8'h02, 1'b0);
        put(8'h11, 1'b0);
        i_gamma_bus_master.stop();
        idle();
        chk("ignored", high_group_outputs[2], 8'h55);
        i_gamma_bus_master.start();
        put(8'hea, 1'b1);
        put(8'h02, 1'b1);
        put(8'h11, 1'b1);
        i_gamma_bus_master.stop();
        idle();
        chk("select high", high_group_outputs[2], 8'h11);
        @(posedge clk);
        #2 address_select_pin = 1'b0;
        $display("test address done");
    endtask

    ////////////////////////////////////////////////////////////////////////////
    task automatic close_out;
        $display("compared %0d mismatched %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    initial begin
        do_reset();
        t_power();
        t_mode0();
        t_mode1();
        t_reserved();
        t_address();
        close_out();
    end

    // whole run is near 0.13 ms of bus traffic
    initial begin
        #2_000_000;
        mismatches++;
        close_out();
    end
endmodule
